// ===== verilog/aacr_pkg.sv
// Purpose: Constants and types shared by the analog control register bank
// Assumes: Register indices are word offsets; bus byte address is index times four
// Notes: Only the four ADC control registers are stored; rest of range reads zero
package aacr_pkg;

   // ==========================================================
   // Register map
   // ==========================================================
   localparam int AACR_NREG = 4;
   localparam logic [13:0] AACR_RANGE_LO_IDX = 14'h2858;
   localparam logic [13:0] AACR_RANGE_HI_IDX = 14'h2868;
   localparam logic [13:0] AACR_GAIN_IDX = 14'h2858;
   localparam logic [13:0] AACR_BIAS_IDX = 14'h2859;
   localparam logic [13:0] AACR_INTEG_IDX = 14'h285a;
   localparam logic [13:0] AACR_COMP_IDX = 14'h285b;
   localparam logic [3:0][13:0] AACR_REG_IDX =
      {AACR_COMP_IDX, AACR_INTEG_IDX, AACR_BIAS_IDX, AACR_GAIN_IDX};

   // Writable bits per register, reserved bits stay zero
   localparam logic [3:0][7:0] AACR_WMASK = {8'h1a, 8'h1f, 8'h0f, 8'h7f};
   // Values after reset
   localparam logic [3:0][7:0] AACR_RESET = {8'h00, 8'h00, 8'h00, 8'h00};

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int AACR_VGAIN_BIT = 6;
   localparam int AACR_BGAIN_LSB = 3;
   localparam int AACR_AGAIN_LSB = 0;
   localparam int AACR_BIAS2_LSB = 2;
   localparam int AACR_BIAS1_LSB = 0;
   localparam int AACR_AMPBIAS_BIT = 4;
   localparam int AACR_RSTM_BIT = 3;
   localparam int AACR_RSTU_BIT = 2;
   localparam int AACR_RSTB_BIT = 1;
   localparam int AACR_RSTA_BIT = 0;
   localparam int AACR_BOOST_BIT = 4;
   localparam int AACR_VSHORT_BIT = 3;
   localparam int AACR_ISHORT_BIT = 1;

   // ==========================================================
   // Bus responses
   // ==========================================================
   localparam logic [1:0] AACR_RESP_OKAY = 2'h0;
   localparam logic [1:0] AACR_RESP_SLVERR = 2'h2;

   // Decoded gain exponent: gain is two to this power
   localparam logic [2:0] AACR_LOG2_X1 = 3'h0;
   localparam logic [2:0] AACR_LOG2_X4 = 3'h2;
   localparam logic [2:0] AACR_LOG2_X8 = 3'h3;
   localparam logic [2:0] AACR_LOG2_X16 = 3'h4;
   localparam logic [2:0] AACR_LOG2_X32 = 3'h5;

   // Bus slave and decode state of the top module
   typedef struct packed {
      logic aw_full;
      logic [13:0] aw_idx;
      logic w_full;
      logic [7:0] w_data;
      logic w_strb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
      logic [2:0] b_gain_log2;
      logic [2:0] a_gain_log2;
   } aacr_state_t;

   // State of one stored byte
   typedef struct packed {
      logic [7:0] value;
   } aacr_byte_state_t;

endpackage // aacr_pkg

// ===== verilog/aacr_reg_if.sv
// Purpose: Write port and stored value of one control byte
// Assumes: One writer, one owner
// Notes: Owner masks reserved bits
interface aacr_reg_if;
   logic wr_en;
   logic [7:0] wr_data;
   logic [7:0] q;

   // Storage side
   modport owner (input wr_en, input wr_data, output q);
   // Decode side
   modport user (output wr_en, output wr_data, input q);
endinterface // aacr_reg_if

// ===== verilog/aacr_byte_reg.sv
// Purpose: One byte of static analog control storage
// Assumes: Synchronous active-low reset
// Notes: Bits outside WMASK always read zero
module aacr_byte_reg
   import aacr_pkg::*;
#(
   parameter logic [7:0] WMASK = 8'hff,
   parameter logic [7:0] RESET = 8'h00
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register port
   aacr_reg_if.owner port
);

   aacr_byte_state_t st;
   aacr_byte_state_t next_st;

   // ==========================================================
   // Next value: hold unless written
   // ==========================================================
   // hold unless written
   always_comb
   begin
      next_st = st;
      if (port.wr_en)
      begin
         next_st.value = port.wr_data & WMASK;
      end
   end

   // State register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st.value <= RESET & WMASK;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign port.q = st.value;

   // ==========================================================
   // Checks
   // ==========================================================
   a_reserved_zero: assert property (@(posedge aclk) (st.value & ~WMASK) == 8'h00)
      else $error("reserved bits of control byte not zero");

endmodule // aacr_byte_reg

// ===== verilog/aacr_regs.sv
// Purpose: AXI4-Lite bank of analog front end control registers
// Assumes: aresetn combines power-on, brown-out, pin and watchdog resets
// Notes: Fields drive static analog control outputs
//
// Contract
// - Range 0x2858 to 0x2868 readable and writable
// - Every system reset restores register defaults
// - Bit 6 voltage gain, software keeps zero
// - Bits 5:3 channel B gain, upper codes x32
// - Bits 2:0 channel A gain, same encoding
// - Bits 3:2 second order bias scale
// - Bits 1:0 first order bias scale
// - Bit 4 voltage amplifier bias scale
// - Bits 3:0 per channel integrator reset
// - Bit 4 comparator bias boost
// - Bit 3 shorts voltage channel input
// - Bit 1 shorts current channel inputs
//
// The AXI4-Lite interface to the registers is this design's own decision.
module aacr_regs
   import aacr_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [15:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [15:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Gain controls
   output logic voltage_pga_gain,
   output logic [2:0] current_b_pga_gain,
   output logic [2:0] current_a_pga_gain,
   output logic [2:0] current_b_gain_log2,
   output logic [2:0] current_a_gain_log2,
   // Bias controls
   output logic [1:0] second_order_bias_scale,
   output logic [1:0] first_order_bias_scale,
   output logic voltage_amp_bias_scale,
   output logic comparator_bias_boost,
   // Integrator resets
   output logic multifunc_integrator_reset,
   output logic voltage_integrator_reset,
   output logic current_b_integrator_reset,
   output logic current_a_integrator_reset,
   // Input shorts
   output logic voltage_input_short,
   output logic current_input_short
);

   aacr_state_t st;
   aacr_state_t next_st;
   logic aw_hs;
   logic w_hs;
   logic ar_hs;
   logic do_write;
   logic [3:0] wr_hit;
   logic [3:0][7:0] reg_q;
   logic [13:0] ar_idx;
   logic [7:0] held_wdata;

   aacr_reg_if reg_bus [AACR_NREG] ();

   // ==========================================================
   // Gain code decode
   // ==========================================================
   function automatic logic [2:0] gain_log2(input logic [2:0] code);
      logic [2:0] res;
      res = AACR_LOG2_X32;
      case (code)
         3'h0: res = AACR_LOG2_X1;
         3'h1: res = AACR_LOG2_X4;
         3'h2: res = AACR_LOG2_X8;
         3'h3: res = AACR_LOG2_X16;
         default: res = AACR_LOG2_X32;
      endcase
      return res;
   endfunction

   // In the documented analog range
   function automatic logic in_range(input logic [13:0] idx);
      return (idx >= AACR_RANGE_LO_IDX) && (idx <= AACR_RANGE_HI_IDX);
   endfunction

   // ==========================================================
   // Handshakes
   // ==========================================================
   assign s_axi_awready = !st.aw_full && !st.bvalid;
   assign s_axi_wready = !st.w_full && !st.bvalid;
   assign s_axi_arready = !st.rvalid;
   assign aw_hs = s_axi_awvalid && s_axi_awready;
   assign w_hs = s_axi_wvalid && s_axi_wready;
   assign ar_hs = s_axi_arvalid && s_axi_arready;
   assign do_write = st.aw_full && st.w_full && !st.bvalid;
   assign ar_idx = s_axi_araddr[15:2];
   assign held_wdata = st.w_data;

   // ==========================================================
   // Storage bytes
   // ==========================================================
   genvar gi;
   generate
      for (gi = 0; gi < AACR_NREG; gi++)
      begin : g_reg
         assign wr_hit[gi] = do_write && st.w_strb0 && (st.aw_idx == AACR_REG_IDX[gi]);
         assign reg_bus[gi].wr_en = wr_hit[gi];
         assign reg_bus[gi].wr_data = st.w_data;
         assign reg_q[gi] = reg_bus[gi].q;
         aacr_byte_reg #(
            .WMASK(AACR_WMASK[gi]),
            .RESET(AACR_RESET[gi])
         ) u_byte (
            .aclk(aclk),
            .aresetn(aresetn),
            .port(reg_bus[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Bus slave next state
   // ==========================================================
   always_comb
   begin
      next_st = st;
      // Capture address and data in either order
      if (aw_hs)
      begin
         next_st.aw_full = 1'b1;
         next_st.aw_idx = s_axi_awaddr[15:2];
      end
      if (w_hs)
      begin
         next_st.w_full = 1'b1;
         next_st.w_data = s_axi_wdata[7:0];
         next_st.w_strb0 = s_axi_wstrb[0];
      end
      if (do_write)
      begin
         next_st.aw_full = 1'b0;
         next_st.w_full = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = in_range(st.aw_idx) ? AACR_RESP_OKAY : AACR_RESP_SLVERR;
      end
      if (st.bvalid && s_axi_bready)
      begin
         next_st.bvalid = 1'b0;
      end
      if (wr_hit[0])
      begin
         next_st.b_gain_log2 = gain_log2(st.w_data[AACR_BGAIN_LSB +: 3]);
         next_st.a_gain_log2 = gain_log2(st.w_data[AACR_AGAIN_LSB +: 3]);
      end
      if (ar_hs)
      begin
         next_st.rvalid = 1'b1;
         next_st.rdata = 8'h00;
         next_st.rresp = in_range(ar_idx) ? AACR_RESP_OKAY : AACR_RESP_SLVERR;
         for (int i = 0; i < AACR_NREG; i++)
         begin
            if (ar_idx == AACR_REG_IDX[i])
            begin
               next_st.rdata = reg_q[i];
            end
         end
      end
      if (st.rvalid && s_axi_rready)
      begin
         next_st.rvalid = 1'b0;
      end
   end

   // State register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Bus outputs
   // ==========================================================
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rresp = st.rresp;
   assign s_axi_rdata = {24'h000000, st.rdata};

   // ==========================================================
   // Static analog controls
   // ==========================================================
   // voltage gain bit
   assign voltage_pga_gain = reg_q[0][AACR_VGAIN_BIT];
   assign current_b_pga_gain = reg_q[0][AACR_BGAIN_LSB +: 3];
   assign current_b_gain_log2 = st.b_gain_log2;
   assign current_a_pga_gain = reg_q[0][AACR_AGAIN_LSB +: 3];
   assign current_a_gain_log2 = st.a_gain_log2;
   assign second_order_bias_scale = reg_q[1][AACR_BIAS2_LSB +: 2];
   assign first_order_bias_scale = reg_q[1][AACR_BIAS1_LSB +: 2];
   assign voltage_amp_bias_scale = reg_q[2][AACR_AMPBIAS_BIT];
   assign multifunc_integrator_reset = reg_q[2][AACR_RSTM_BIT];
   assign voltage_integrator_reset = reg_q[2][AACR_RSTU_BIT];
   assign current_b_integrator_reset = reg_q[2][AACR_RSTB_BIT];
   assign current_a_integrator_reset = reg_q[2][AACR_RSTA_BIT];
   assign comparator_bias_boost = reg_q[3][AACR_BOOST_BIT];
   assign voltage_input_short = reg_q[3][AACR_VSHORT_BIT];
   assign current_input_short = reg_q[3][AACR_ISHORT_BIT];

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_reset_defaults: assert property (
      @(posedge aclk) disable iff (1'b0)
      !aresetn |=> (reg_q == AACR_RESET) && !s_axi_bvalid && !s_axi_rvalid)
      else $error("registers not at defaults after reset");

   a_write_stores: assert property (
      wr_hit[3] |=> reg_q[3] == ($past(held_wdata) & AACR_WMASK[3]))
      else $error("written control byte not stored");

   a_write_answer: assert property (
      do_write |=> s_axi_bvalid && (s_axi_bresp == AACR_RESP_OKAY) == in_range($past(st.aw_idx)))
      else $error("write response wrong");

   a_voltage_gain: assert property (
      wr_hit[0] |=> voltage_pga_gain == $past(held_wdata[AACR_VGAIN_BIT]))
      else $error("voltage gain bit not taken");

   a_b_gain_sat: assert property (
      current_b_pga_gain[2] |-> current_b_gain_log2 == AACR_LOG2_X32)
      else $error("channel B gain not x32");

   a_a_gain_decode: assert property (
      current_a_pga_gain == 3'h1 |-> current_a_gain_log2 == AACR_LOG2_X4)
      else $error("channel A gain decode wrong");

   a_bias_scale: assert property (
      wr_hit[1] |=> second_order_bias_scale == $past(held_wdata[AACR_BIAS2_LSB +: 2]))
      else $error("second order bias not taken");

   a_static_hold: assert property (
      !do_write [*2] |-> $stable(reg_q))
      else $error("control output changed without write");

   a_integ_hold: assert property (
      voltage_integrator_reset && !wr_hit[2] |=> voltage_integrator_reset)
      else $error("integrator reset cleared itself");

   a_boost_write: assert property (
      wr_hit[3] ##1 1'b1 |-> comparator_bias_boost == $past(held_wdata[AACR_BOOST_BIT]))
      else $error("comparator boost not taken");

   // Main scenarios
   c_write_done: cover property (s_axi_bvalid && s_axi_bready);
   c_read_done: cover property (s_axi_rvalid && s_axi_rready && s_axi_rdata != 32'h0);
   c_integ_reset: cover property (current_a_integrator_reset ##[1:20] !current_a_integrator_reset);

endmodule // aacr_regs

// ===== verification/test_adc_analog_control_regs.sv
// Purpose: Self-checking bench for the analog control register bank
// Assumes: Bus byte address is register index times four
// Notes: Bench drives every bus channel itself, no partner model
module test_adc_analog_control_regs
   import aacr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // Signals
   // ==========================================================
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [15:0] s_axi_awaddr = 16'h0;
   logic [15:0] s_axi_araddr = 16'h0;
   logic [2:0] s_axi_awprot = 3'h0;
   logic [2:0] s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic voltage_pga_gain, voltage_amp_bias_scale, comparator_bias_boost;
   logic [2:0] current_b_pga_gain, current_a_pga_gain;
   logic [2:0] current_b_gain_log2, current_a_gain_log2;
   logic [1:0] second_order_bias_scale, first_order_bias_scale;
   logic multifunc_integrator_reset, voltage_integrator_reset;
   logic current_b_integrator_reset, current_a_integrator_reset;
   logic voltage_input_short, current_input_short;
   int n_mismatch = 0;
   int n_tests = 0;

   // Clock, 100 ns period
   always #50 aclk = ~aclk;

   // Device under test
   aacr_regs aacr_regs_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .voltage_pga_gain, .current_b_pga_gain, .current_a_pga_gain,
      .current_b_gain_log2, .current_a_gain_log2, .second_order_bias_scale,
      .first_order_bias_scale, .voltage_amp_bias_scale, .comparator_bias_boost,
      .multifunc_integrator_reset, .voltage_integrator_reset,
      .current_b_integrator_reset, .current_a_integrator_reset,
      .voltage_input_short, .current_input_short);

   // ==========================================================
   // Checking and closing
   // ==========================================================
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Wait limit ran out
   task automatic hang();
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
      finish_test();
   endtask

   // Gain code to exponent of two
   function automatic logic [2:0] gexp(input logic [2:0] c);
      case (c)
         3'h0: return 3'h0;
         3'h1: return 3'h2;
         3'h2: return 3'h3;
         3'h3: return 3'h4;
         default: return 3'h5;
      endcase
   endfunction

   // ==========================================================
   // Bus tasks, entered just after a rising edge
   // ==========================================================
   task automatic axi_wr(input logic [13:0] idx, input logic [31:0] d,
                         input logic [3:0] strb, output logic [1:0] resp);
      logic aw_hit, w_hit, b_hit;
      int n;
      aw_hit = 1'b0;
      w_hit = 1'b0;
      b_hit = 1'b0;
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= d;
      s_axi_wstrb <= strb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 50 && !(aw_hit && w_hit); n++)
      begin
         @(negedge aclk);
         aw_hit = aw_hit || (s_axi_awvalid && s_axi_awready === 1'b1);
         w_hit = w_hit || (s_axi_wvalid && s_axi_wready === 1'b1);
         @(posedge aclk);
         if (aw_hit)
            s_axi_awvalid <= 1'b0;
         if (w_hit)
            s_axi_wvalid <= 1'b0;
      end
      if (!(aw_hit && w_hit))
         hang();
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50 && !b_hit; n++)
      begin
         @(negedge aclk);
         b_hit = (s_axi_bvalid === 1'b1);
         resp = s_axi_bresp;
         @(posedge aclk);
      end
      s_axi_bready <= 1'b0;
      if (!b_hit)
         hang();
   endtask

   task automatic axi_rd(input logic [13:0] idx, output logic [31:0] d,
                         output logic [1:0] resp);
      logic hit;
      int n;
      hit = 1'b0;
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 50 && !hit; n++)
      begin
         @(negedge aclk);
         hit = (s_axi_arready === 1'b1);
         @(posedge aclk);
      end
      if (!hit)
         hang();
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      hit = 1'b0;
      for (n = 0; n < 50 && !hit; n++)
      begin
         @(negedge aclk);
         hit = (s_axi_rvalid === 1'b1);
         d = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge aclk);
      end
      s_axi_rready <= 1'b0;
      if (!hit)
         hang();
   endtask

   // Full-byte write with response compare
   task automatic wr(input logic [13:0] idx, input logic [7:0] d, input logic [1:0] rexp);
      logic [1:0] r;
      axi_wr(idx, {24'h0, d}, 4'h1, r);
      chk({30'h0, r}, {30'h0, rexp});
   endtask

   // Read with data and response compare
   task automatic rd(input logic [13:0] idx, input logic [7:0] exp, input logic [1:0] rexp);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(idx, d, r);
      chk(d, {24'h0, exp});
      chk({30'h0, r}, {30'h0, rexp});
   endtask

   // Control outputs against expected register images
   task automatic outs(input logic [7:0] g, input logic [7:0] bi, input logic [7:0] it,
                       input logic [7:0] cp);
      chk({25'h0, voltage_pga_gain, current_b_pga_gain, current_a_pga_gain}, {25'h0, g[6:0]});
      chk({26'h0, current_b_gain_log2, current_a_gain_log2}, {26'h0, gexp(g[5:3]), gexp(g[2:0])});
      chk({28'h0, second_order_bias_scale, first_order_bias_scale}, {28'h0, bi[3:0]});
      chk({27'h0, voltage_amp_bias_scale, multifunc_integrator_reset, voltage_integrator_reset,
           current_b_integrator_reset, current_a_integrator_reset}, {27'h0, it[4:0]});
      chk({29'h0, comparator_bias_boost, voltage_input_short, current_input_short},
          {29'h0, cp[4], cp[3], cp[1]});
   endtask

   task automatic do_reset(input int cycles);
      aresetn <= 1'b0;
      repeat (cycles) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial
   begin
      int i;
      logic [7:0] v;
      logic [1:0] r;
      @(posedge aclk);
      do_reset(16);
      for (i = 0; i < 4; i++)
         rd(AACR_REG_IDX[i], 8'h00, AACR_RESP_OKAY);
      outs(8'h00, 8'h00, 8'h00, 8'h00);
      for (i = 0; i < 8; i++)
      begin
         v = {2'b00, i[2:0], 3'(7 - i)};
         wr(AACR_GAIN_IDX, v, AACR_RESP_OKAY);
         rd(AACR_GAIN_IDX, v, AACR_RESP_OKAY);
         outs(v, 8'h00, 8'h00, 8'h00);
      end
      wr(AACR_GAIN_IDX, 8'h49, AACR_RESP_OKAY);
      rd(AACR_GAIN_IDX, 8'h49, AACR_RESP_OKAY);
      outs(8'h49, 8'h00, 8'h00, 8'h00);
      for (i = 0; i < 16; i++)
      begin
         v = {4'h0, i[3:0]};
         wr(AACR_BIAS_IDX, v, AACR_RESP_OKAY);
         outs(8'h49, v, 8'h00, 8'h00);
      end
      wr(AACR_INTEG_IDX, 8'h1f, AACR_RESP_OKAY);
      outs(8'h49, 8'h0f, 8'h1f, 8'h00);
      wr(AACR_COMP_IDX, 8'h1a, AACR_RESP_OKAY);
      rd(AACR_COMP_IDX, 8'h1a, AACR_RESP_OKAY);
      outs(8'h49, 8'h0f, 8'h1f, 8'h1a);
      for (i = 0; i < 5; i++)
      begin
         v = 8'h01 << i;
         wr(AACR_INTEG_IDX, v, AACR_RESP_OKAY);
         outs(8'h49, 8'h0f, v, 8'h1a);
      end
      axi_wr(AACR_COMP_IDX, 32'h0, 4'h0, r);
      chk({30'h0, r}, {30'h0, AACR_RESP_OKAY});
      outs(8'h49, 8'h0f, 8'h10, 8'h1a);
      wr(14'h285f, 8'h00, AACR_RESP_OKAY);
      rd(14'h285f, 8'h00, AACR_RESP_OKAY);
      wr(AACR_RANGE_HI_IDX, 8'h33, AACR_RESP_OKAY);
      rd(AACR_RANGE_HI_IDX, 8'h00, AACR_RESP_OKAY);
      wr(14'h2869, 8'h11, AACR_RESP_SLVERR);
      rd(14'h2869, 8'h00, AACR_RESP_SLVERR);
      wr(14'h2857, 8'h22, AACR_RESP_SLVERR);
      rd(14'h2857, 8'h00, AACR_RESP_SLVERR);
      outs(8'h49, 8'h0f, 8'h10, 8'h1a);
      do_reset(3);
      for (i = 0; i < 4; i++)
         rd(AACR_REG_IDX[i], 8'h00, AACR_RESP_OKAY);
      outs(8'h00, 8'h00, 8'h00, 8'h00);
      // Recommended image copied back after reset
      wr(AACR_GAIN_IDX, 8'h12, AACR_RESP_OKAY);
      wr(AACR_BIAS_IDX, 8'h00, AACR_RESP_OKAY);
      rd(AACR_GAIN_IDX, 8'h12, AACR_RESP_OKAY);
      outs(8'h12, 8'h00, 8'h00, 8'h00);
      finish_test();
   end
endmodule // test_adc_analog_control_regs
